// ===== rtl/smp_bank.sv
// second-motor parameter bank with range-checked writes and profile switch
//
// What this block does
// - hold first acceleration time, 32-bit hi/lo pair, 1..360000 x 0.01 s.
// - hold first deceleration time, 32-bit hi/lo pair, 1..360000 x 0.01 s.
// - base frequency accepts 30 up to current maximum frequency, 1 Hz steps.
// - maximum frequency accepts 30 to 400, 1 Hz steps.
// - multispeed frequency pair, zero or start frequency to maximum, 0.01 Hz.
// - boost method decodes 0 as manual, 1 as automatic.
// - manual boost amount accepts 0 to 200, 0.1 percent steps.
// - manual boost frequency adjustment accepts 0 to 500, 0.1 percent.
// - V/f curve codes 0..4: const, reduced, free, vector, zero-Hz vector.
// - automatic boost voltage gain accepts 0 to 255.
// - upper limit pair, zero or lower limit to maximum, 0.01 Hz.
// - lower limit pair, zero or start frequency to maximum, 0.01 Hz.
// - alternate acceleration time pair, 1..360000 x 0.01 s.
// - alternate deceleration time pair, 1..360000 x 0.01 s.
// - switch method: 0 terminal, 1 set frequency, 2 on reversal only.
// - accel switch frequency pair accepts 0 to 40000, 0.01 Hz.
// - decel switch frequency pair accepts 0 to 40000, 0.01 Hz.
`timescale 1ns/100ps
`default_nettype none

module smp_bank (
  input  wire logic           i_core_clk,
  input  wire logic           i_resetn,
  input  wire logic [15:0]    i_addr,
  input  wire logic [15:0]    i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output logic [15:0]         o_rdata,
  output logic                o_wr_reject,
  input  wire logic [31:0]    i_start_freq,
  input  wire logic [31:0]    i_out_freq,
  input  wire logic           i_reversing,
  input  wire logic           i_profile_select_input,
  output smp_pkg::smp_cfg_t   o_cfg,
  output logic                o_alt_accel,
  output logic                o_alt_decel
);
  import smp_pkg::*;

  smp_state_t st_q;
  smp_state_t st_d;

  function automatic logic in_rng(input logic [31:0] v,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  logic [31:0] mx100;
  logic [31:0] pv;
  logic [15:0] hi_addr;
  logic [15:0] cur_hi;
  logic        ok;

  // hi word of the pair addressed by a low-word write
  always_comb begin
    hi_addr = i_addr - 16'h0001;
    case (i_addr)
      ADDR_ACCEL_LO:   cur_hi = st_q.cfg.accel_time[31:16];
      ADDR_DECEL_LO:   cur_hi = st_q.cfg.decel_time[31:16];
      ADDR_MSPD_LO:    cur_hi = st_q.cfg.multispeed_freq[31:16];
      ADDR_ULIM_LO:    cur_hi = st_q.cfg.freq_upper_limit[31:16];
      ADDR_LLIM_LO:    cur_hi = st_q.cfg.freq_lower_limit[31:16];
      ADDR_ALT_ACC_LO: cur_hi = st_q.cfg.alt_accel_time[31:16];
      ADDR_ALT_DEC_LO: cur_hi = st_q.cfg.alt_decel_time[31:16];
      ADDR_ACC_SW_LO:  cur_hi = st_q.cfg.accel_switch_freq[31:16];
      ADDR_DEC_SW_LO:  cur_hi = st_q.cfg.decel_switch_freq[31:16];
      default:         cur_hi = 16'h0000;
    endcase
    // a staged hi word only pairs with the low word of its own register
    if (st_q.stg_vld && (st_q.stg_tag == hi_addr)) begin
      pv = {st_q.stg_hi, i_wdata};
    end else begin
      pv = {cur_hi, i_wdata};
    end
    mx100 = 32'(st_q.cfg.max_freq) * HZ_TO_CENTI;
  end

  always_comb begin
    st_d        = st_q;
    st_d.reject = 1'b0;
    st_d.rdata  = 16'h0000;
    ok          = 1'b1;

    // pin passes two flops before use
    st_d.pin_s1 = i_profile_select_input;
    st_d.pin_s2 = st_q.pin_s1;

    if (i_wr) begin
      case (i_addr)
        // hi words only stage; the low word commits the whole value
        ADDR_ACCEL_HI, ADDR_DECEL_HI, ADDR_MSPD_HI, ADDR_ULIM_HI,
        ADDR_LLIM_HI, ADDR_ALT_ACC_HI, ADDR_ALT_DEC_HI,
        ADDR_ACC_SW_HI, ADDR_DEC_SW_HI: begin
          st_d.stg_hi  = i_wdata;
          st_d.stg_tag = i_addr;
          st_d.stg_vld = 1'b1;
        end
        ADDR_ACCEL_LO: begin
          ok = in_rng(pv, TIME_MIN, TIME_MAX);
          if (ok) begin
            st_d.cfg.accel_time = pv;
          end
        end
        ADDR_DECEL_LO: begin
          ok = in_rng(pv, TIME_MIN, TIME_MAX);
          if (ok) begin
            st_d.cfg.decel_time = pv;
          end
        end
        ADDR_BASE_FREQ: begin
          ok = (i_wdata >= FREQ_HZ_MIN) && (i_wdata <= st_q.cfg.max_freq);
          if (ok) begin
            st_d.cfg.base_freq = i_wdata;
          end
        end
        ADDR_MAX_FREQ: begin
          ok = (i_wdata >= FREQ_HZ_MIN) && (i_wdata <= FREQ_HZ_MAX);
          if (ok) begin
            st_d.cfg.max_freq = i_wdata;
          end
        end
        ADDR_MSPD_LO: begin
          ok = (pv == 32'h0000_0000) || in_rng(pv, i_start_freq, mx100);
          if (ok) begin
            st_d.cfg.multispeed_freq = pv;
          end
        end
        ADDR_BOOST_METH: begin
          ok = (i_wdata <= BOOST_CODE_MAX);
          if (ok) begin
            st_d.cfg.boost_method = smp_boost_t'(i_wdata[0]);
          end
        end
        ADDR_MAN_BOOST: begin
          ok = (i_wdata <= MAN_BOOST_MAX);
          if (ok) begin
            st_d.cfg.manual_boost_amount = i_wdata;
          end
        end
        ADDR_BOOST_ADJ: begin
          ok = (i_wdata <= BOOST_ADJ_MAX);
          if (ok) begin
            st_d.cfg.manual_boost_freq_adj = i_wdata;
          end
        end
        ADDR_VF_CURVE: begin
          ok = (i_wdata <= VF_CODE_MAX);
          if (ok) begin
            st_d.cfg.vf_curve_select = smp_vf_t'(i_wdata[2:0]);
          end
        end
        ADDR_VOLT_GAIN: begin
          ok = (i_wdata <= GAIN_MAX);
          if (ok) begin
            st_d.cfg.auto_boost_volt_gain = i_wdata[7:0];
          end
        end
        ADDR_SLIP_GAIN: begin
          ok = (i_wdata <= GAIN_MAX);
          if (ok) begin
            st_d.cfg.auto_boost_slip_gain = i_wdata[7:0];
          end
        end
        ADDR_ULIM_LO: begin
          ok = (pv == 32'h0000_0000)
            || in_rng(pv, st_q.cfg.freq_lower_limit, mx100);
          if (ok) begin
            st_d.cfg.freq_upper_limit = pv;
          end
        end
        ADDR_LLIM_LO: begin
          ok = (pv == 32'h0000_0000) || in_rng(pv, i_start_freq, mx100);
          if (ok) begin
            st_d.cfg.freq_lower_limit = pv;
          end
        end
        ADDR_ALT_ACC_LO: begin
          ok = in_rng(pv, TIME_MIN, TIME_MAX);
          if (ok) begin
            st_d.cfg.alt_accel_time = pv;
          end
        end
        ADDR_ALT_DEC_LO: begin
          ok = in_rng(pv, TIME_MIN, TIME_MAX);
          if (ok) begin
            st_d.cfg.alt_decel_time = pv;
          end
        end
        ADDR_SW_METH: begin
          ok = (i_wdata <= SW_CODE_MAX);
          if (ok) begin
            st_d.cfg.profile_switch_method = smp_sw_t'(i_wdata[1:0]);
          end
        end
        ADDR_ACC_SW_LO: begin
          ok = (pv <= SW_FREQ_MAX);
          if (ok) begin
            st_d.cfg.accel_switch_freq = pv;
          end
        end
        ADDR_DEC_SW_LO: begin
          ok = (pv <= SW_FREQ_MAX);
          if (ok) begin
            st_d.cfg.decel_switch_freq = pv;
          end
        end
        default: begin
          ok = 1'b0;
        end
      endcase
      // any low-word or single write ends a pending pair
      if (st_d.stg_tag != i_addr) begin
        st_d.stg_vld = 1'b0;
      end
      st_d.reject = ~ok;
    end

    if (i_rd) begin
      case (i_addr)
        ADDR_ACCEL_HI:   st_d.rdata = st_q.cfg.accel_time[31:16];
        ADDR_ACCEL_LO:   st_d.rdata = st_q.cfg.accel_time[15:0];
        ADDR_DECEL_HI:   st_d.rdata = st_q.cfg.decel_time[31:16];
        ADDR_DECEL_LO:   st_d.rdata = st_q.cfg.decel_time[15:0];
        ADDR_BASE_FREQ:  st_d.rdata = st_q.cfg.base_freq;
        ADDR_MAX_FREQ:   st_d.rdata = st_q.cfg.max_freq;
        ADDR_MSPD_HI:    st_d.rdata = st_q.cfg.multispeed_freq[31:16];
        ADDR_MSPD_LO:    st_d.rdata = st_q.cfg.multispeed_freq[15:0];
        ADDR_BOOST_METH: st_d.rdata = {15'h0000, st_q.cfg.boost_method};
        ADDR_MAN_BOOST:  st_d.rdata = st_q.cfg.manual_boost_amount;
        ADDR_BOOST_ADJ:  st_d.rdata = st_q.cfg.manual_boost_freq_adj;
        ADDR_VF_CURVE:   st_d.rdata = {13'h0000, st_q.cfg.vf_curve_select};
        ADDR_VOLT_GAIN:  st_d.rdata = {8'h00, st_q.cfg.auto_boost_volt_gain};
        ADDR_SLIP_GAIN:  st_d.rdata = {8'h00, st_q.cfg.auto_boost_slip_gain};
        ADDR_ULIM_HI:    st_d.rdata = st_q.cfg.freq_upper_limit[31:16];
        ADDR_ULIM_LO:    st_d.rdata = st_q.cfg.freq_upper_limit[15:0];
        ADDR_LLIM_HI:    st_d.rdata = st_q.cfg.freq_lower_limit[31:16];
        ADDR_LLIM_LO:    st_d.rdata = st_q.cfg.freq_lower_limit[15:0];
        ADDR_ALT_ACC_HI: st_d.rdata = st_q.cfg.alt_accel_time[31:16];
        ADDR_ALT_ACC_LO: st_d.rdata = st_q.cfg.alt_accel_time[15:0];
        ADDR_ALT_DEC_HI: st_d.rdata = st_q.cfg.alt_decel_time[31:16];
        ADDR_ALT_DEC_LO: st_d.rdata = st_q.cfg.alt_decel_time[15:0];
        ADDR_SW_METH:    st_d.rdata = {14'h0000, st_q.cfg.profile_switch_method};
        ADDR_ACC_SW_HI:  st_d.rdata = st_q.cfg.accel_switch_freq[31:16];
        ADDR_ACC_SW_LO:  st_d.rdata = st_q.cfg.accel_switch_freq[15:0];
        ADDR_DEC_SW_HI:  st_d.rdata = st_q.cfg.decel_switch_freq[31:16];
        ADDR_DEC_SW_LO:  st_d.rdata = st_q.cfg.decel_switch_freq[15:0];
        // reserved reads as zero
        default:         st_d.rdata = 16'h0000;
      endcase
    end

    case (st_q.cfg.profile_switch_method)
      SMP_SW_TERMINAL: begin
        st_d.alt_accel = st_q.pin_s2;
        st_d.alt_decel = st_q.pin_s2;
      end
      SMP_SW_FREQ: begin
        st_d.alt_accel = (i_out_freq >= st_q.cfg.accel_switch_freq);
        st_d.alt_decel = (i_out_freq <  st_q.cfg.decel_switch_freq);
      end
      SMP_SW_REVERSE: begin
        st_d.alt_accel = i_reversing;
        st_d.alt_decel = i_reversing;
      end
      default: begin
        st_d.alt_accel = 1'b0;
        st_d.alt_decel = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q                           <= '0;
      st_q.cfg.accel_time            <= RST_TIME;
      st_q.cfg.decel_time            <= RST_TIME;
      st_q.cfg.alt_accel_time        <= RST_TIME;
      st_q.cfg.alt_decel_time        <= RST_TIME;
      st_q.cfg.base_freq             <= RST_FREQ_HZ;
      st_q.cfg.max_freq              <= RST_FREQ_HZ;
      st_q.cfg.auto_boost_volt_gain  <= RST_GAIN[7:0];
      st_q.cfg.auto_boost_slip_gain  <= RST_GAIN[7:0];
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata     = st_q.rdata;
  assign o_wr_reject = st_q.reject;
  assign o_cfg       = st_q.cfg;
  assign o_alt_accel = st_q.alt_accel;
  assign o_alt_decel = st_q.alt_decel;

endmodule

`default_nettype wire

// ===== include/smp_pkg.sv
// package for the second-motor parameter bank: map, limits, types
package smp_pkg;

  // register word addresses
  localparam logic [15:0] ADDR_ACCEL_HI    = 16'h2103;
  localparam logic [15:0] ADDR_ACCEL_LO    = 16'h2104;
  localparam logic [15:0] ADDR_DECEL_HI    = 16'h2105;
  localparam logic [15:0] ADDR_DECEL_LO    = 16'h2106;
  localparam logic [15:0] ADDR_BASE_FREQ   = 16'h2203;
  localparam logic [15:0] ADDR_MAX_FREQ    = 16'h2204;
  localparam logic [15:0] ADDR_MSPD_HI     = 16'h2216;
  localparam logic [15:0] ADDR_MSPD_LO     = 16'h2217;
  localparam logic [15:0] ADDR_BOOST_METH  = 16'h223b;
  localparam logic [15:0] ADDR_MAN_BOOST   = 16'h223c;
  localparam logic [15:0] ADDR_BOOST_ADJ   = 16'h223d;
  localparam logic [15:0] ADDR_VF_CURVE    = 16'h223e;
  localparam logic [15:0] ADDR_VOLT_GAIN   = 16'h2240;
  localparam logic [15:0] ADDR_SLIP_GAIN   = 16'h2241;
  localparam logic [15:0] ADDR_ULIM_HI     = 16'h224f;
  localparam logic [15:0] ADDR_ULIM_LO     = 16'h2250;
  localparam logic [15:0] ADDR_LLIM_HI     = 16'h2251;
  localparam logic [15:0] ADDR_LLIM_LO     = 16'h2252;
  localparam logic [15:0] ADDR_ALT_ACC_HI  = 16'h226f;
  localparam logic [15:0] ADDR_ALT_ACC_LO  = 16'h2270;
  localparam logic [15:0] ADDR_ALT_DEC_HI  = 16'h2271;
  localparam logic [15:0] ADDR_ALT_DEC_LO  = 16'h2272;
  localparam logic [15:0] ADDR_SW_METH     = 16'h2273;
  localparam logic [15:0] ADDR_ACC_SW_HI   = 16'h2274;
  localparam logic [15:0] ADDR_ACC_SW_LO   = 16'h2275;
  localparam logic [15:0] ADDR_DEC_SW_HI   = 16'h2276;
  localparam logic [15:0] ADDR_DEC_SW_LO   = 16'h2277;

  // value limits
  localparam logic [31:0] TIME_MIN         = 32'h0000_0001;
  localparam logic [31:0] TIME_MAX         = 32'd360000;
  localparam logic [15:0] FREQ_HZ_MIN      = 16'd30;
  localparam logic [15:0] FREQ_HZ_MAX      = 16'd400;
  localparam logic [31:0] HZ_TO_CENTI      = 32'd100;
  localparam logic [15:0] MAN_BOOST_MAX    = 16'd200;
  localparam logic [15:0] BOOST_ADJ_MAX    = 16'd500;
  localparam logic [15:0] GAIN_MAX         = 16'd255;
  localparam logic [31:0] SW_FREQ_MAX      = 32'd40000;
  localparam logic [15:0] VF_CODE_MAX      = 16'd4;
  localparam logic [15:0] SW_CODE_MAX      = 16'd2;
  localparam logic [15:0] BOOST_CODE_MAX   = 16'd1;

  // reset values
  localparam logic [31:0] RST_TIME         = 32'd1000;
  localparam logic [15:0] RST_FREQ_HZ      = 16'd60;
  localparam logic [15:0] RST_GAIN         = 16'd100;

  typedef enum logic [0:0] {
    SMP_BOOST_MANUAL = 1'b0,
    SMP_BOOST_AUTO   = 1'b1
  } smp_boost_t;

  typedef enum logic [2:0] {
    SMP_VF_CONST_TQ  = 3'b000,
    SMP_VF_REDUCED   = 3'b001,
    SMP_VF_FREE      = 3'b010,
    SMP_VF_SLV       = 3'b011,
    SMP_VF_SLV_ZERO  = 3'b100
  } smp_vf_t;

  typedef enum logic [1:0] {
    SMP_SW_TERMINAL  = 2'b00,
    SMP_SW_FREQ      = 2'b01,
    SMP_SW_REVERSE   = 2'b10
  } smp_sw_t;

  // settings as seen by the drive logic
  typedef struct packed {
    logic [31:0] accel_time;
    logic [31:0] decel_time;
    logic [15:0] base_freq;
    logic [15:0] max_freq;
    logic [31:0] multispeed_freq;
    smp_boost_t  boost_method;
    logic [15:0] manual_boost_amount;
    logic [15:0] manual_boost_freq_adj;
    smp_vf_t     vf_curve_select;
    logic [7:0]  auto_boost_volt_gain;
    logic [7:0]  auto_boost_slip_gain;
    logic [31:0] freq_upper_limit;
    logic [31:0] freq_lower_limit;
    logic [31:0] alt_accel_time;
    logic [31:0] alt_decel_time;
    smp_sw_t     profile_switch_method;
    logic [31:0] accel_switch_freq;
    logic [31:0] decel_switch_freq;
  } smp_cfg_t;

  // whole module state
  typedef struct packed {
    smp_cfg_t    cfg;
    logic [15:0] stg_hi;
    logic [15:0] stg_tag;
    logic        stg_vld;
    logic [15:0] rdata;
    logic        reject;
    logic        pin_s1;
    logic        pin_s2;
    logic        alt_accel;
    logic        alt_decel;
  } smp_state_t;

endpackage

// ===== tb/smp_bank_props.sv
// checker for the second-motor parameter bank
`timescale 1ns/100ps
`default_nettype none
module smp_bank_props (
  input wire logic               i_core_clk,
  input wire logic               i_resetn,
  input wire logic [15:0]        i_addr,
  input wire logic [15:0]        i_wdata,
  input wire logic               i_wr,
  input wire logic               i_reversing,
  input wire logic               o_wr_reject,
  input wire smp_pkg::smp_cfg_t  o_cfg,
  input wire logic               o_alt_accel,
  input wire logic               o_alt_decel
);
  import smp_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_max_rng;
    o_cfg.max_freq inside {[FREQ_HZ_MIN:FREQ_HZ_MAX]};
  endproperty
  a_max_rng: assert property (p_max_rng) else $error("max frequency out of range");
  property p_acc_rng;
    o_cfg.accel_time inside {[TIME_MIN:TIME_MAX]};
  endproperty
  a_acc_rng: assert property (p_acc_rng) else $error("accel time out of range");
  property p_boost_rng;
    o_cfg.manual_boost_amount <= MAN_BOOST_MAX && o_cfg.manual_boost_freq_adj <= BOOST_ADJ_MAX;
  endproperty
  a_boost_rng: assert property (p_boost_rng) else $error("boost setting out of range");
  property p_code_rng;
    o_cfg.vf_curve_select <= SMP_VF_SLV_ZERO && o_cfg.profile_switch_method <= SMP_SW_REVERSE;
  endproperty
  a_code_rng: assert property (p_code_rng) else $error("mode code out of range");
  property p_swf_rng;
    o_cfg.accel_switch_freq <= SW_FREQ_MAX && o_cfg.decel_switch_freq <= SW_FREQ_MAX;
  endproperty
  a_swf_rng: assert property (p_swf_rng) else $error("switch point out of range");
  property p_base;
    $changed(o_cfg.base_freq) |-> o_cfg.base_freq >= FREQ_HZ_MIN
      && o_cfg.base_freq <= o_cfg.max_freq;
  endproperty
  a_base: assert property (p_base) else $error("base frequency took a bad value");
  property p_max_wr;
    i_wr && i_addr == ADDR_MAX_FREQ && i_wdata inside {[FREQ_HZ_MIN:FREQ_HZ_MAX]}
      |=> o_cfg.max_freq == $past(i_wdata) && !o_wr_reject;
  endproperty
  a_max_wr: assert property (p_max_wr) else $error("max frequency write not taken");
  property p_rej;
    o_wr_reject |-> $past(i_wr) && $stable(o_cfg);
  endproperty
  a_rej: assert property (p_rej) else $error("refused write changed settings");
  property p_quiet;
    !$past(i_wr) |-> $stable(o_cfg) && !o_wr_reject;
  endproperty
  a_quiet: assert property (p_quiet) else $error("settings moved without a write");
  property p_rev;
    (o_cfg.profile_switch_method == SMP_SW_REVERSE && $stable(i_reversing))[*3]
      |-> o_alt_accel == i_reversing && o_alt_decel == i_reversing;
  endproperty
  a_rev: assert property (p_rev) else $error("profile not following reversal");
endmodule
bind smp_bank smp_bank_props smp_bank_props_inst (
  .i_core_clk  (i_core_clk),
  .i_resetn    (i_resetn),
  .i_addr      (i_addr),
  .i_wdata     (i_wdata),
  .i_wr        (i_wr),
  .i_reversing (i_reversing),
  .o_wr_reject (o_wr_reject),
  .o_cfg       (o_cfg),
  .o_alt_accel (o_alt_accel),
  .o_alt_decel (o_alt_decel)
);
`default_nettype wire

// ===== tb/smp_host_model.sv
// register bus master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module smp_host_model (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_wr_reject,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr  = 16'h0;
    o_wdata = 16'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // released bus shows inverted values so a stale latch is not hidden
  task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic rej);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
    @(posedge i_core_clk);
    rej = i_wr_reject;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_smp_bank.sv
// self-checking bench for the second-motor parameter bank
`timescale 1ns/100ps
`default_nettype none
module test_smp_bank;
  import smp_pkg::*;
  logic        clk, resetn, wr, rd, rej, reversing, pin, alt_acc, alt_dec;
  logic [15:0] addr, wdata, rdata;
  logic [31:0] start_freq, out_freq;
  smp_cfg_t    cfg;
  int          n_mismatch, num_checks;
  smp_bank smp_bank_inst (.i_core_clk(clk), .i_resetn(resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_wr_reject(rej),
    .i_start_freq(start_freq), .i_out_freq(out_freq), .i_reversing(reversing),
    .i_profile_select_input(pin), .o_cfg(cfg), .o_alt_accel(alt_acc), .o_alt_decel(alt_dec));
  smp_host_model smp_host_model_inst (.i_core_clk(clk), .i_rdata(rdata), .i_wr_reject(rej),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // pairs go high word first, low word commits
  task automatic wr32(input logic [15:0] a, input bit w, input logic [31:0] v, output logic r);
    if (w) smp_host_model_inst.wr(a, v[31:16], r);
    smp_host_model_inst.wr(w ? a + 16'h1 : a, v[15:0], r);
  endtask
  task automatic rd32(input logic [15:0] a, input bit w, output logic [31:0] v);
    logic [15:0] h, l;
    h = 16'h0;
    if (w) smp_host_model_inst.rd(a, h);
    smp_host_model_inst.rd(w ? a + 16'h1 : a, l);
    v = {h, l};
  endtask
  task automatic acc(input logic [15:0] a, input bit w, input logic [31:0] v, input bit ok);
    logic [31:0] old, now;
    logic        r;
    rd32(a, w, old);
    wr32(a, w, v, r);
    rd32(a, w, now);
    chk("refusal flag", {31'h0, !ok}, {31'h0, r});
    chk("read back", ok ? v : old, now);
  endtask
  // ends of the range taken, one step beyond refused
  task automatic rng(input logic [15:0] a, input bit w, input logic [31:0] lo, input logic [31:0] hi);
    if (hi <= 32'd4) for (int v = 0; v <= hi; v++) acc(a, w, 32'(v), 1'b1);
    acc(a, w, lo, 1'b1);
    acc(a, w, hi, 1'b1);
    acc(a, w, hi + 32'd1, 1'b0);
    if (lo != 32'd0) acc(a, w, lo - 32'd1, 1'b0);
  endtask
  task automatic waitf(input logic ea, input logic ed);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      if (alt_acc === ea && alt_dec === ed) break;
    end
    // a missed level ends the run at once through the common verdict
    if (i == 12) begin
      n_mismatch++;
      test_done();
    end else begin
      chk("alt accel", {31'h0, ea}, {31'h0, alt_acc});
      chk("alt decel", {31'h0, ed}, {31'h0, alt_dec});
    end
  endtask
  task automatic t_reset;
    logic [31:0] v;
    rd32(ADDR_ACCEL_HI, 1'b1, v);
    chk("accel time", RST_TIME, v);
    rd32(ADDR_MAX_FREQ, 1'b0, v);
    chk("max freq", {16'h0, RST_FREQ_HZ}, v);
    rd32(ADDR_VOLT_GAIN, 1'b0, v);
    chk("volt gain", {16'h0, RST_GAIN}, v);
    $display("t_reset done");
  endtask
  task automatic t_ranges;
    rng(ADDR_MAX_FREQ, 1'b0, 32'd30, 32'd400);
    rng(ADDR_BASE_FREQ, 1'b0, 32'd30, 32'd400);
    acc(ADDR_MSPD_HI, 1'b1, 32'd0, 1'b1);
    rng(ADDR_MSPD_HI, 1'b1, start_freq, 32'd40000);
    rng(ADDR_LLIM_HI, 1'b1, start_freq, 32'd40000);
    acc(ADDR_LLIM_HI, 1'b1, 32'd1000, 1'b1);
    rng(ADDR_ULIM_HI, 1'b1, 32'd1000, 32'd40000);
    rng(ADDR_ACCEL_HI, 1'b1, 32'd1, TIME_MAX);
    rng(ADDR_DECEL_HI, 1'b1, 32'd1, TIME_MAX);
    rng(ADDR_ALT_ACC_HI, 1'b1, 32'd1, TIME_MAX);
    rng(ADDR_ALT_DEC_HI, 1'b1, 32'd1, TIME_MAX);
    rng(ADDR_ACC_SW_HI, 1'b1, 32'd0, 32'd40000);
    rng(ADDR_DEC_SW_HI, 1'b1, 32'd0, 32'd40000);
    rng(ADDR_MAN_BOOST, 1'b0, 32'd0, 32'd200);
    rng(ADDR_BOOST_ADJ, 1'b0, 32'd0, 32'd500);
    rng(ADDR_VOLT_GAIN, 1'b0, 32'd0, 32'd255);
    rng(ADDR_VF_CURVE, 1'b0, 32'd0, 32'd4);
    rng(ADDR_SW_METH, 1'b0, 32'd0, 32'd2);
    rng(ADDR_BOOST_METH, 1'b0, 32'd0, 32'd1);
    chk("boost decode", {31'h0, SMP_BOOST_AUTO}, {31'h0, cfg.boost_method});
    $display("t_ranges done");
  endtask
  task automatic t_addr;
    logic [31:0] v;
    acc(16'h2107, 1'b0, 32'd5, 1'b0);
    acc(16'h223f, 1'b0, 32'd5, 1'b0);
    rd32(16'h2278, 1'b0, v);
    chk("unmapped read", 32'h0, v);
    $display("t_addr done");
  endtask
  // switch points both sit at 40000 after the range test
  task automatic t_switch;
    logic r;
    wr32(ADDR_SW_METH, 1'b0, 32'd2, r);
    reversing <= 1'b1;
    waitf(1'b1, 1'b1);
    reversing <= 1'b0;
    wr32(ADDR_SW_METH, 1'b0, 32'd0, r);
    pin <= 1'b1;
    waitf(1'b1, 1'b1);
    wr32(ADDR_SW_METH, 1'b0, 32'd1, r);
    out_freq <= 32'd40000;
    waitf(1'b1, 1'b0);
    out_freq <= 32'd39999;
    waitf(1'b0, 1'b1);
    $display("t_switch done");
  endtask
  initial begin
    resetn     = 1'b0;
    start_freq = 32'd500;
    out_freq   = 32'd0;
    reversing  = 1'b0;
    pin        = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ranges();
    t_addr();
    t_switch();
    test_done();
  end
endmodule
`default_nettype wire
